// file: core/tmf_defs.svh
`ifndef TMF_DEFS_SVH
`define TMF_DEFS_SVH

// Register byte offsets inside the 4 KiB window.
`define TMF_OFS_CTRL     12'h000
`define TMF_OFS_FLAG     12'h004
`define TMF_OFS_STS      12'h008
`define TMF_OFS_MSK      12'h00c
// Upper address nibble selecting the target and pattern arrays.
`define TMF_TGT_PAGE     4'h1
`define TMF_PAT_PAGE     4'h2

// Control register bit positions.
`define TMF_CTRL_BAND    0
`define TMF_CTRL_EXT0    1
`define TMF_CTRL_EXT1    2
`define TMF_CTRL_W       3

// Reset values.
`define TMF_CTRL_RST     3'h0
`define TMF_ENT_RST      32'h0000_0000

// Bus response codes.
`define TMF_RESP_OKAY    2'h0
`define TMF_RESP_SLVERR  2'h2

`endif

// file: core/tmf_pkg.sv
package tmf_pkg;

	// Slot of a pattern inside one comparison entry.
	typedef enum logic [1:0] {
		TMF_UP_SET,
		TMF_UP_RST,
		TMF_DN_SET,
		TMF_DN_RST
	} tmf_pat_t;

	// AXI response code.
	typedef logic [1:0] tmf_resp_t;

endpackage : tmf_pkg

// file: core/tmf_entry.sv
`timescale 1ns/100ps
// One comparison entry: equality test and direction-dependent pattern choice.
module tmf_entry
	import tmf_pkg::*;
#(
	parameter int CNT_W  = 32,
	parameter int N_FLAG = 16
) (
	// Count from the counter core.
	input  wire logic [CNT_W-1:0]  count,
	input  wire logic              dn,
	// Entry contents.
	input  wire logic [CNT_W-1:0]  target,
	input  wire logic [N_FLAG-1:0] up_set,
	input  wire logic [N_FLAG-1:0] up_rst,
	input  wire logic [N_FLAG-1:0] dn_set,
	input  wire logic [N_FLAG-1:0] dn_rst,
	// Result.
	output logic                   hit,
	output logic [N_FLAG-1:0]      set_m,
	output logic [N_FLAG-1:0]      rst_m
);

	// ring as linear
	// Equality compare; linear and ring counts are treated alike.
	assign hit = (count == target);

	always_comb begin
		if (dn) begin
			set_m = dn_set;
			rst_m = dn_rst;
		end else begin
			set_m = up_set;
			rst_m = up_rst;
		end
	end

endmodule : tmf_entry

// file: core/tmf_match.sv
// Notes on behaviour
// - Counting up, a target match sets the up-set flags and clears the up-reset flags.
// - Counting down, a target match sets the down-set flags and clears the down-reset flags.
// - Up and down patterns of an entry are stored and applied independently.
// - Conflicting actions of simultaneous matches resolve to the lowest entry index.
// - Entries 0 to 15 exist and may hold equal or overlapping targets.
// - A ring counter gets exactly the same direction-dependent behaviour as a linear one.
// - Up to sixteen match flags are kept and are readable by software.
// - One pattern may select any number of flags at once.
// - External outputs 0 and 1 may follow flags 0 and 1, and are off by default.
// - Target match or band comparison is chosen per channel; band idles this logic.
`timescale 1ns/100ps
`include "tmf_defs.svh"

module tmf_match
	import tmf_pkg::*;
#(
	parameter int CNT_W  = 32,
	parameter int N_ENT  = 16,
	parameter int N_FLAG = 16
) (
	// Clock, reset and freeze.
	input  wire logic              CORE_CLK,
	input  wire logic              RESET_N,
	input  wire logic              CLK_EN,
	// Counter core.
	input  wire logic [CNT_W-1:0]  COUNT,
	input  wire logic              COUNT_DN,
	input  wire logic              COUNT_STB,
	// Flags and terminals.
	output logic [N_FLAG-1:0]      FLAGS,
	output logic                   EXT_OUT0,
	output logic                   EXT_OUT1,
	output logic                   IRQ,
	// AXI4-Lite write channels.
	input  wire logic [11:0]       S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	// AXI4-Lite read channels.
	input  wire logic [11:0]       S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY
);

	// Refuse sizes that the address map or the data word cannot hold.
	if (CNT_W < 1 || CNT_W > 32 || N_ENT < 1 || N_ENT > 16 || N_FLAG < 2 || N_FLAG > 16) begin : g_bad
		$error("tmf_match: unsupported parameter values");
	end

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic [N_ENT-1:0][CNT_W-1:0]       tgt;
		logic [N_ENT-1:0][3:0][N_FLAG-1:0] pat;
		logic [N_FLAG-1:0]                 flag;
		logic [N_FLAG-1:0]                 sts;
		logic [N_FLAG-1:0]                 msk;
		logic [`TMF_CTRL_W-1:0]            ctrl;
		logic [1:0]                        ext;
		logic                              aw_held;
		logic [11:0]                       awaddr;
		logic                              w_held;
		logic [31:0]                       wdata;
		logic [3:0]                        wstrb;
		logic                              bvalid;
		tmf_resp_t                         bresp;
		logic                              rvalid;
		logic [31:0]                       rdata;
		tmf_resp_t                         rresp;
	} tmf_state_t;

	tmf_state_t st_ff;
	tmf_state_t nxt_st;

	logic [N_ENT-1:0]             hit;
	logic [N_ENT-1:0][N_FLAG-1:0] set_m;
	logic [N_ENT-1:0][N_FLAG-1:0] rst_m;
	logic [N_FLAG-1:0]            touch;
	logic                         band;

	assign band = st_ff.ctrl[`TMF_CTRL_BAND];

	// Byte-lane merge of a write into an old word.
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
	                                        input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return res;
	endfunction : wmerge

	////////////////////////////////////////////////////////////////////////////////
	// Comparison entries.

	for (genvar g = 0; g < N_ENT; g++) begin : g_ent
		tmf_entry #(
			.CNT_W  (CNT_W),
			.N_FLAG (N_FLAG)
		) u_ent (
			.count  (COUNT),
			.dn     (COUNT_DN),
			.target (st_ff.tgt[g]),
			.up_set (st_ff.pat[g][TMF_UP_SET]),
			.up_rst (st_ff.pat[g][TMF_UP_RST]),
			.dn_set (st_ff.pat[g][TMF_DN_SET]),
			.dn_rst (st_ff.pat[g][TMF_DN_RST]),
			.hit    (hit[g]),
			.set_m  (set_m[g]),
			.rst_m  (rst_m[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Handshake outputs.

	// Readies drop while frozen so that no beat is taken and lost.
	assign S_AXI_AWREADY = CLK_EN && !st_ff.aw_held && !st_ff.bvalid;
	assign S_AXI_WREADY  = CLK_EN && !st_ff.w_held && !st_ff.bvalid;
	assign S_AXI_ARREADY = CLK_EN && !st_ff.rvalid;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb begin
		logic [N_FLAG-1:0] f;
		logic [N_FLAG-1:0] clr;
		logic              wr_go;
		logic              wr_ok;
		logic [11:0]       wa;
		logic [11:0]       ra;
		logic [31:0]       rd;
		logic              rd_ok;
		f      = st_ff.flag;
		clr    = '0;
		touch  = '0;
		wr_go  = 1'b0;
		wr_ok  = 1'b0;
		wa     = '0;
		ra     = S_AXI_ARADDR;
		rd     = '0;
		rd_ok  = 1'b0;
		nxt_st = st_ff;

		// highest index first
		// Entries are applied from 15 down to 0, so entry 0 acts last and wins.
		// band mode idles
		if (COUNT_STB && !band) begin
			for (int i = N_ENT - 1; i >= 0; i--) begin
				if (hit[i]) begin
					// apply set/reset; set wins inside one entry.
					f     = (f & ~rst_m[i]) | set_m[i];
					touch = touch | rst_m[i] | set_m[i];
				end
			end
		end
		nxt_st.flag = f;

		// Write address and data are caught in either order.
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.awaddr  = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			nxt_st.w_held = 1'b1;
			nxt_st.wdata  = S_AXI_WDATA;
			nxt_st.wstrb  = S_AXI_WSTRB;
		end

		// Register write once both halves are held.
		wr_go = st_ff.aw_held && st_ff.w_held;
		wa    = st_ff.awaddr;
		if (wr_go) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held  = 1'b0;
			nxt_st.bvalid  = 1'b1;
			if (wa == `TMF_OFS_CTRL) begin
				nxt_st.ctrl = `TMF_CTRL_W'(wmerge(32'(st_ff.ctrl), st_ff.wdata, st_ff.wstrb));
				wr_ok = 1'b1;
			end else if (wa == `TMF_OFS_FLAG) begin
				wr_ok = 1'b1;
			end else if (wa == `TMF_OFS_STS) begin
				clr   = N_FLAG'(wmerge(32'h0, st_ff.wdata, st_ff.wstrb));
				wr_ok = 1'b1;
			end else if (wa == `TMF_OFS_MSK) begin
				nxt_st.msk = N_FLAG'(wmerge(32'(st_ff.msk), st_ff.wdata, st_ff.wstrb));
				wr_ok = 1'b1;
			end else if (wa[11:8] == `TMF_TGT_PAGE && wa[7:6] == 2'h0 && int'(wa[5:2]) < N_ENT) begin
				nxt_st.tgt[wa[5:2]] = CNT_W'(wmerge(32'(st_ff.tgt[wa[5:2]]), st_ff.wdata,
				                                    st_ff.wstrb));
				wr_ok = 1'b1;
			end else if (wa[11:8] == `TMF_PAT_PAGE && int'(wa[7:4]) < N_ENT) begin
				nxt_st.pat[wa[7:4]][wa[3:2]] = N_FLAG'(wmerge(32'(st_ff.pat[wa[7:4]][wa[3:2]]),
				                                              st_ff.wdata, st_ff.wstrb));
				wr_ok = 1'b1;
			end
			nxt_st.bresp = wr_ok ? `TMF_RESP_OKAY : `TMF_RESP_SLVERR;
		end
		if (st_ff.bvalid && S_AXI_BREADY) begin
			nxt_st.bvalid = 1'b0;
		end

		// Sticky change events; a new event beats a clear in the same cycle.
		nxt_st.sts = (st_ff.sts & ~clr) | (f ^ st_ff.flag);

		// terminals from flags 0 and 1
		nxt_st.ext[0] = nxt_st.flag[0] & nxt_st.ctrl[`TMF_CTRL_EXT0];
		nxt_st.ext[1] = nxt_st.flag[1] & nxt_st.ctrl[`TMF_CTRL_EXT1];

		// Read decode; unmapped addresses answer SLVERR with zero data.
		if (ra == `TMF_OFS_CTRL) begin
			rd    = 32'(st_ff.ctrl);
			rd_ok = 1'b1;
		end else if (ra == `TMF_OFS_FLAG) begin
			rd    = 32'(st_ff.flag);
			rd_ok = 1'b1;
		end else if (ra == `TMF_OFS_STS) begin
			rd    = 32'(st_ff.sts);
			rd_ok = 1'b1;
		end else if (ra == `TMF_OFS_MSK) begin
			rd    = 32'(st_ff.msk);
			rd_ok = 1'b1;
		end else if (ra[11:8] == `TMF_TGT_PAGE && ra[7:6] == 2'h0 && int'(ra[5:2]) < N_ENT) begin
			rd    = 32'(st_ff.tgt[ra[5:2]]);
			rd_ok = 1'b1;
		end else if (ra[11:8] == `TMF_PAT_PAGE && int'(ra[7:4]) < N_ENT) begin
			rd    = 32'(st_ff.pat[ra[7:4]][ra[3:2]]);
			rd_ok = 1'b1;
		end
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = rd;
			nxt_st.rresp  = rd_ok ? `TMF_RESP_OKAY : `TMF_RESP_SLVERR;
		end else if (st_ff.rvalid && S_AXI_RREADY) begin
			nxt_st.rvalid = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// All state is held while the clock enable is low.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_ff      <= '0;
			st_ff.ctrl <= `TMF_CTRL_RST;
		end else if (CLK_EN) begin
			st_ff <= nxt_st;
		end
	end

	// Registered outputs.
	assign FLAGS        = st_ff.flag;
	assign EXT_OUT0     = st_ff.ext[0];
	assign EXT_OUT1     = st_ff.ext[1];
	assign S_AXI_BVALID = st_ff.bvalid;
	assign S_AXI_BRESP  = st_ff.bresp;
	assign S_AXI_RVALID = st_ff.rvalid;
	assign S_AXI_RDATA  = st_ff.rdata;
	assign S_AXI_RRESP  = st_ff.rresp;

	// Interrupt: any unmasked sticky change event.
	assign IRQ = |(st_ff.sts & st_ff.msk);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	logic ev_up0;
	logic ev_dn0;
	assign ev_up0 = CLK_EN && COUNT_STB && !band && !COUNT_DN && hit[0];
	assign ev_dn0 = CLK_EN && COUNT_STB && !band && COUNT_DN && hit[0];

	AST_UP_SET: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		ev_up0 |=> (FLAGS & $past(st_ff.pat[0][TMF_UP_SET])) == $past(st_ff.pat[0][TMF_UP_SET]))
		else $error("up-count set pattern not applied");
	AST_UP_RST: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		ev_up0 |=> (FLAGS & $past(st_ff.pat[0][TMF_UP_RST] & ~st_ff.pat[0][TMF_UP_SET])) == '0)
		else $error("up-count reset pattern not applied");
	AST_DN_SET: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		ev_dn0 |=> (FLAGS & $past(st_ff.pat[0][TMF_DN_SET])) == $past(st_ff.pat[0][TMF_DN_SET]))
		else $error("down-count set pattern not applied");
	AST_DN_RST: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		ev_dn0 |=> (FLAGS & $past(st_ff.pat[0][TMF_DN_RST] & ~st_ff.pat[0][TMF_DN_SET])) == '0)
		else $error("down-count reset pattern not applied");
	AST_ONLY_TOUCHED: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		CLK_EN |=> ((FLAGS ^ $past(FLAGS)) & ~$past(touch)) == '0)
		else $error("flag changed outside the applied patterns");
	AST_NO_MATCH: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		(!COUNT_STB || hit == '0) |=> $stable(FLAGS))
		else $error("flags changed without a target match");
	AST_BAND_IDLE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		band |=> $stable(FLAGS))
		else $error("flags changed in band mode");
	AST_EXT: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		{EXT_OUT1, EXT_OUT0} == (FLAGS[1:0] & st_ff.ctrl[`TMF_CTRL_EXT1:`TMF_CTRL_EXT0]))
		else $error("external terminals disagree with flags");
	AST_IRQ: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		(CLK_EN && (FLAGS != nxt_st.flag) && (nxt_st.msk & (FLAGS ^ nxt_st.flag)) != '0) |=> IRQ)
		else $error("unmasked flag change did not raise the interrupt");
	AST_BRESP: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		(CLK_EN && st_ff.aw_held && st_ff.w_held) |=> S_AXI_BVALID)
		else $error("write response missing");
	AST_RRESP: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		(S_AXI_ARVALID && S_AXI_ARREADY) |=> S_AXI_RVALID)
		else $error("read response missing");

	COV_UP: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) ev_up0 ##1 FLAGS != '0);
	COV_DN: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) ev_dn0);
	COV_MULTI: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
		COUNT_STB && !band && $countones(hit) > 1);
	COV_IRQ: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) $rose(IRQ));

endmodule : tmf_match

// file: tb/tmf_count_model.sv
`timescale 1ns/100ps
// Counter core stand-in: loads a start value, then steps once per cycle with a strobe.
module tmf_count_model #(
	parameter int CNT_W    = 32,
	parameter int RING_TOP = 15
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Control from the bench.
	input  wire logic             run,
	input  wire logic             dn,
	input  wire logic             ring,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_val,
	// Count towards the block.
	output logic [CNT_W-1:0]      count,
	output logic                  count_dn,
	output logic                  count_stb
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} tmf_mdl_st_t;
	localparam logic [CNT_W-1:0] TOP = CNT_W'(RING_TOP);
	tmf_mdl_st_t st_ff;
	tmf_mdl_st_t nxt_st;
	// ring wrap
	// Next count: load, wrap at the ring limits, or step by one.
	always_comb begin
		nxt_st = st_ff;
		if (load)
			nxt_st.cnt = load_val;
		else if (run && ring && !dn && st_ff.cnt == TOP)
			nxt_st.cnt = '0;
		else if (run && ring && dn && st_ff.cnt == '0)
			nxt_st.cnt = TOP;
		else if (run)
			nxt_st.cnt = dn ? st_ff.cnt - 1'b1 : st_ff.cnt + 1'b1;
	end
	// State register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	// Outside a strobe the count is not valid, so the inverse is shown to expose misuse.
	assign count     = run ? st_ff.cnt : ~st_ff.cnt;
	assign count_dn  = dn;
	assign count_stb = run;
endmodule : tmf_count_model

// file: tb/test_target_match_flag_logic.sv
`timescale 1ns/100ps
`include "tmf_defs.svh"
module test_target_match_flag_logic
	import tmf_pkg::*;
();
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        clk_en = 1'b1;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        run = 1'b0;
	logic        dn = 1'b0;
	logic        ring = 1'b0;
	logic        load = 1'b0;
	logic [31:0] load_val = 32'h0;
	logic [31:0] count;
	logic        count_dn;
	logic        count_stb;
	logic [15:0] flags;
	logic        ext0;
	logic        ext1;
	logic        irq;
	logic        awready;
	logic        wready;
	logic        bvalid;
	logic        arready;
	logic        rvalid;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [31:0] rdata;
	int          n_fail = 0;
	int          compares = 0;

	// Clock of 25 ns.
	always #12.5 clk = ~clk;

	tmf_count_model #(.CNT_W(32), .RING_TOP(15)) cnt_u (.clk(clk), .rst_n(rst_n), .run(run),
		.dn(dn), .ring(ring), .load(load), .load_val(load_val), .count(count),
		.count_dn(count_dn), .count_stb(count_stb));

	tmf_match #(.CNT_W(32), .N_ENT(16), .N_FLAG(16)) dut_u (.CORE_CLK(clk), .RESET_N(rst_n),
		.CLK_EN(clk_en), .COUNT(count), .COUNT_DN(count_dn), .COUNT_STB(count_stb),
		.FLAGS(flags), .EXT_OUT0(ext0), .EXT_OUT1(ext1), .IRQ(irq),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

	////////////////////////////////////////////////////////////////////////
	// Compares one value and counts the outcome.
	task chk(input string what, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %0s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// Bus write; address and data are released as each is taken.
	task axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ap;
		logic wp;
		ap = 1'b1;
		wp = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (!ap && !wp && bvalid) begin
				chk("bresp", {30'h0, er}, {30'h0, bresp});
				bready <= 1'b0;
				break;
			end
			if (ap && awready) begin
				ap = 1'b0;
				awvalid <= 1'b0;
			end
			if (wp && wready) begin
				wp = 1'b0;
				wvalid <= 1'b0;
			end
		end
	endtask : axw

	// Bus read with expected data and response.
	task axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ap;
		ap = 1'b1;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (!ap && rvalid) begin
				chk("rdata", ed, rdata);
				chk("rresp", {30'h0, er}, {30'h0, rresp});
				rready <= 1'b0;
				break;
			end
			if (ap && arready) begin
				ap = 1'b0;
				arvalid <= 1'b0;
			end
		end
	endtask : axr

	// Entry target and pattern writes.
	task tgt(input int i, input logic [31:0] v);
		axw(12'h100 + 12'(4 * i), v, `TMF_RESP_OKAY);
	endtask : tgt
	task pat(input int i, input tmf_pat_t k, input logic [31:0] v);
		axw(12'h200 + 12'(16 * i) + 12'(4 * int'(k)), v, `TMF_RESP_OKAY);
	endtask : pat

	// Lets the counter run n strobes from s, then waits for the flags to land.
	task sweep(input logic [31:0] s, input logic d, input logic r, input int n);
		@(posedge clk);
		load <= 1'b1;
		load_val <= s;
		dn <= d;
		ring <= r;
		@(posedge clk);
		load <= 1'b0;
		run <= 1'b1;
		repeat (n) @(posedge clk);
		run <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : sweep

	task endt(input string s);
		$display("test %0s done", s);
	endtask : endt

	// Prints the counts and the verdict, then ends the run.
	task report_and_stop;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////
	// Watchdog against a hung handshake.
	initial begin
		repeat (6000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end

	// Main test sequence.
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		chk("flags", 32'h0, {16'h0, flags});
		axr(`TMF_OFS_CTRL, 32'h0, `TMF_RESP_OKAY);
		axr(12'hffc, 32'h0, `TMF_RESP_SLVERR);
		axw(12'hffc, 32'h1, `TMF_RESP_SLVERR);
		endt("reset");
		tgt(0, 32'd100);
		tgt(1, 32'd200);
		tgt(2, 32'd300);
		tgt(15, 32'd300);
		tgt(3, 32'd2);
		pat(0, TMF_UP_SET, 32'h000f);
		pat(1, TMF_UP_RST, 32'h0003);
		pat(1, TMF_DN_SET, 32'h0100);
		pat(1, TMF_DN_RST, 32'h0004);
		pat(2, TMF_UP_RST, 32'h0100);
		pat(15, TMF_UP_SET, 32'h4100);
		pat(3, TMF_UP_SET, 32'h0200);
		pat(3, TMF_DN_RST, 32'h0200);
		sweep(32'd95, 1'b0, 1'b0, 10);
		chk("flags", 32'h000f, {16'h0, flags});
		chk("ext0", 32'h0, {31'h0, ext0});
		axw(`TMF_OFS_CTRL, 32'h2, `TMF_RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("ext0", 32'h1, {31'h0, ext0});
		chk("ext1", 32'h0, {31'h0, ext1});
		axw(`TMF_OFS_MSK, 32'h1, `TMF_RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		axw(`TMF_OFS_STS, 32'h1, `TMF_RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		axr(`TMF_OFS_STS, 32'h000e, `TMF_RESP_OKAY);
		axw(`TMF_OFS_FLAG, 32'h0, `TMF_RESP_OKAY);
		axr(`TMF_OFS_FLAG, 32'h000f, `TMF_RESP_OKAY);
		endt("up_set");
		sweep(32'd195, 1'b0, 1'b0, 10);
		chk("flags", 32'h000c, {16'h0, flags});
		sweep(32'd205, 1'b1, 1'b0, 10);
		chk("flags", 32'h0108, {16'h0, flags});
		sweep(32'd105, 1'b1, 1'b0, 10);
		chk("flags", 32'h0108, {16'h0, flags});
		endt("direction");
		sweep(32'd295, 1'b0, 1'b0, 10);
		chk("flags", 32'h4008, {16'h0, flags});
		endt("priority");
		sweep(32'd13, 1'b0, 1'b1, 6);
		chk("flags", 32'h4208, {16'h0, flags});
		sweep(32'd4, 1'b1, 1'b1, 6);
		chk("flags", 32'h4008, {16'h0, flags});
		endt("ring");
		axw(`TMF_OFS_CTRL, 32'h1, `TMF_RESP_OKAY);
		sweep(32'd95, 1'b0, 1'b0, 10);
		chk("flags", 32'h4008, {16'h0, flags});
		endt("band");
		// Byte-lane write narrows entry 0 up-set to flag 1, which then drives terminal 1.
		axw(`TMF_OFS_CTRL, 32'h6, `TMF_RESP_OKAY);
		wstrb <= 4'h1;
		pat(0, TMF_UP_SET, 32'hffff_ff02);
		wstrb <= 4'hf;
		axr(12'h200, 32'h0002, `TMF_RESP_OKAY);
		sweep(32'd95, 1'b0, 1'b0, 10);
		chk("flags", 32'h400a, {16'h0, flags});
		chk("ext1", 32'h1, {31'h0, ext1});
		chk("ext0", 32'h0, {31'h0, ext0});
		endt("strobe_ext1");
		// A match at 200 would clear flags 0 and 1, but the clock enable is low.
		clk_en <= 1'b0;
		sweep(32'd195, 1'b0, 1'b0, 10);
		chk("flags", 32'h400a, {16'h0, flags});
		chk("awready", 32'h0, {31'h0, awready});
		clk_en <= 1'b1;
		endt("freeze");
		report_and_stop();
	end
endmodule : test_target_match_flag_logic
